// ### bench/dtc_regs_tb_top.sv
// self-checking bench for the diagnostic test configuration register bank
`timescale 1ns/1ps
module dtc_regs_tb_top;
   import dtc_pkg::*;
   // ------------------------------------------------------------
   // stimulus, observed outputs and bookkeeping
   // ------------------------------------------------------------
   logic              clk_in = 1'b0;
   logic              rst_b_in = 1'b0;
   logic [7:0]        addr_in = 8'h00;
   logic [15:0]       wdata_in = 16'h0000;
   logic              wr_in = 1'b0, rd_in = 1'b0, scan_start_in = 1'b0, scan_done_in = 1'b0;
   logic [14:0]       chan_en_in = 15'h0000, polarity_in = 15'h0000;
   logic [3:0]        gpio_en_in = 4'h0, aux_analog_in = 4'h0;
   logic              ser_en_in = 1'b0;
   logic [2:0]        scan_cfg_in = 3'h0;
   logic [15:0]       rdata_out, amp_expect_out;
   logic [14:0]       meas_sel_out, cell_src_out;
   logic [3:0]        aux_src_out, aux_dis_out;
   logic [1:0]        amp_src_out, amp_mode_out;
   logic              scanning_out, open_mode_out, cmp_low_only_out, open_thr_out;
   logic              adc_cells_out, amp_pullup_out, thermistor_bias_output_gnd_out, amp_exclude_out;
   logic              open_advice_out;
   int                num_errors = 0, n_checks = 0, cycles = 0;
   logic [31:0]       seed = 32'hfcb4_6da1;
   logic [31:0]       r;
   logic [15:0]       d, c_s, a_s, g_s;     // last read data, and register values the snapshot should hold
   logic [15:0]       sh [3];               // shadow of the three registers
   logic [14:0]       e_ch, e_po;           // levels captured at scan start
   logic [3:0]        e_gp, e_an;
   logic              e_se;
   logic [7:0]        a;

   always #12.5 clk_in = ~clk_in;

   dtc_regs dut (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .scan_start_in(scan_start_in),
      .scan_done_in(scan_done_in), .chan_en_in(chan_en_in), .polarity_in(polarity_in),
      .gpio_en_in(gpio_en_in), .ser_en_in(ser_en_in), .aux_analog_in(aux_analog_in),
      .scan_cfg_in(scan_cfg_in), .scanning_out(scanning_out), .meas_sel_out(meas_sel_out),
      .open_mode_out(open_mode_out), .cmp_low_only_out(cmp_low_only_out),
      .open_thr_out(open_thr_out), .adc_cells_out(adc_cells_out), .cell_src_out(cell_src_out),
      .aux_src_out(aux_src_out), .amp_src_out(amp_src_out), .amp_pullup_out(amp_pullup_out),
      .aux_dis_out(aux_dis_out), .thermistor_bias_output_gnd_out(thermistor_bias_output_gnd_out), .amp_mode_out(amp_mode_out),
      .amp_exclude_out(amp_exclude_out), .amp_expect_out(amp_expect_out),
      .open_advice_out(open_advice_out));

   // ------------------------------------------------------------
   // helpers: random source, compare, verdict, bus cycles
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic rnd();
      seed = lfsr(seed);
      r = seed;
   endtask : rnd

   function automatic logic [15:0] amp_exp(input logic [1:0] m);
      case (m)
         2'b01:   return 16'h2000;
         2'b10:   return 16'h3800;
         2'b11:   return 16'h3ffc;
         default: return 16'h0000;
      endcase
   endfunction : amp_exp

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude

   // one-cycle strobes, changed only right after a rising edge
   task automatic reg_wr(input logic [7:0] ad, input logic [15:0] dat);
      @(posedge clk_in);
      addr_in  <= ad;
      wdata_in <= dat;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in    <= 1'b0;
   endtask : reg_wr

   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] ad);
      @(posedge clk_in);
      addr_in <= ad;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      #1 d = rdata_out;
   endtask : reg_rd

   // decode outputs against the snapshot the bench expects
   task automatic check_dec();
      logic op;
      op = c_s[15];
      chk({1'b0, meas_sel_out}, {1'b0, op ? (e_ch & ~e_po) : e_ch});
      chk({13'h0, open_mode_out, cmp_low_only_out, open_thr_out}, {13'h0, {3{op}}});
      chk({15'h0, adc_cells_out}, {15'h0, ~op});
      chk({1'b0, cell_src_out}, {1'b0, c_s[14:0]});
      chk({12'h0, aux_src_out}, {12'h0, a_s[3:0] & ~e_gp & ~{2'b00, {2{e_se}}}});
      chk({14'h0, amp_src_out}, {14'h0, a_s[5:4]});
      chk({15'h0, amp_pullup_out}, 16'h0001);
      chk({11'h0, thermistor_bias_output_gnd_out, aux_dis_out}, {11'h0, (g_s[15:13] == 3'b011) && (|e_an),
          (g_s[15:13] == 3'b010) ? e_an : 4'h0});
      chk({13'h0, amp_exclude_out, amp_mode_out}, {13'h0, g_s[12:11] != 2'b00, g_s[12:11]});
      chk(amp_expect_out, amp_exp(g_s[12:11]));
      chk({15'h0, open_advice_out}, {15'h0, op && (((c_s[14:0] & e_ch & ~e_po) != (e_ch & ~e_po))
          || scan_cfg_in != 3'b010)});
   endtask : check_dec

   // hang guard: the run needs well under two thousand cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         conclude();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_in);
      rst_b_in <= 1'b1;
      sh[0] = 16'h0000; sh[1] = 16'h0000; sh[2] = 16'h0000;
      // reset values plus one unmapped address, then random traffic
      for (int i = 0; i < 4; i++) begin
         reg_rd(8'h6c + i[7:0]);
         chk(d, 16'h0000);
      end
      for (int i = 0; i < 40; i++) begin
         rnd();
         a = (r[17:16] == 2'b11) ? 8'h6f : 8'h6c + {6'h0, r[17:16]};
         reg_wr(a, r[15:0]);
         if (a != 8'h6f) sh[a - 8'h6c] = r[15:0] & ((a == 8'h6c) ? 16'hffff :
                                                    (a == 8'h6d) ? 16'h003f : 16'hf800);
         a = (r[19:18] == 2'b11) ? 8'h6f : 8'h6c + {6'h0, r[19:18]};
         reg_rd(a);
         chk(d, (a == 8'h6f) ? 16'h0000 : sh[a - 8'h6c]);
      end
      // every aux and amplifier mode code, random fields and pin levels
      for (int i = 0; i < 32; i++) begin
         rnd();
         c_s = r[15:0];
         a_s = {10'h000, r[21:16]};
         g_s = {i[2:0], i[4:3], 11'h000};
         reg_wr(8'h6c, c_s);
         reg_wr(8'h6d, a_s);
         reg_wr(8'h6e, g_s | {5'h00, r[26:16]});
         rnd();
         e_ch = r[14:0];
         e_po = r[29:15];
         e_se = r[30];
         e_gp = r[3:0];
         e_an = r[7:4];
         chan_en_in <= e_ch; polarity_in <= e_po; ser_en_in <= e_se;
         gpio_en_in <= e_gp; aux_analog_in <= e_an; scan_cfg_in <= i[0] ? 3'b010 : r[10:8];
         @(posedge clk_in);
         scan_start_in <= 1'b1;
         @(posedge clk_in);
         scan_start_in <= 1'b0;
         repeat (2) @(posedge clk_in);
         #1 chk({15'h0, scanning_out}, 16'h0001);
         check_dec();
         // new settings mid-scan must wait for the next scan
         rnd();
         reg_wr(8'h6c, ~c_s);
         reg_wr(8'h6d, {10'h000, r[5:0]});
         reg_wr(8'h6e, ~g_s);
         chan_en_in <= ~e_ch;
         gpio_en_in <= ~e_gp;
         repeat (3) @(posedge clk_in);
         #1 check_dec();
         @(posedge clk_in);
         scan_done_in <= 1'b1;
         @(posedge clk_in);
         scan_done_in <= 1'b0;
         #1 chk({15'h0, scanning_out}, 16'h0000);
      end
      conclude();
   end
endmodule : dtc_regs_tb_top

// ### design/dtc_decode.sv
// combinational decode of the scan snapshot into diagnostic controls
`timescale 1ns/1ps
module dtc_decode
   import dtc_pkg::*;
(
   dtc_snap_if.dst     snap,            // scan snapshot
   output logic [14:0] meas_sel,        // cells measured this scan
   output logic        open_mode,       // open-wire comparator checks
   output logic [14:0] cell_src_on,     // cell current sources
   output logic [3:0]  aux_src_on,      // aux current sources
   output logic [1:0]  amp_src_on,      // amplifier p,n sources
   output logic [3:0]  aux_discharge,   // accelerated discharge per pin
   output logic        thermistor_bias_output_gnd,        // thermistor bias to analog ground
   output logic [1:0]  amp_mode,        // amplifier diag mode
   output logic        amp_exclude,     // keep amp results out of filter/limits
   output logic [15:0] amp_expect       // expected amp result
);
   logic [2:0] aux_mode;

   // decode of all snapshot fields
   always_comb begin
      aux_mode    = snap.gen_cfg[AUX_MODE_LSB +: 3];
      amp_mode    = snap.gen_cfg[AMP_MODE_LSB +: 2];
      open_mode   = snap.cell_cfg[OPEN_SEL_BIT];
      // polarity only gates selection in open mode [R1] [R2]
      meas_sel    = open_mode ? (snap.chan_en & ~snap.polarity) : snap.chan_en;
      cell_src_on = snap.cell_cfg[CELL_N-1:0];                           // [R5]
      // gpio and serial master pins ignore the enable, readback untouched
      aux_src_on  = snap.aux_cfg[AUX_N-1:0] & ~snap.gpio_en
                    & ~{2'b00, {2{snap.ser_en}}};                        // [R8] [R9] [R10]
      amp_src_on  = {snap.aux_cfg[AMP_P_BIT], snap.aux_cfg[AMP_N_BIT]};  // [R6] [R7]
      aux_discharge = '0;
      thermistor_bias_output_gnd      = 1'b0;
      case (aux_mode)                                                    // [R11]
         DTC_AUX_DISCHARGE: aux_discharge = snap.aux_analog;             // [R12]
         DTC_AUX_THERMISTOR_BIAS_OUTPUT_GND:  thermistor_bias_output_gnd      = |snap.aux_analog;            // [R12]
         default:           aux_discharge = '0;                          // normal, reserved
      endcase
      case (amp_mode)                                                    // [R13]
         DTC_AMP_OFFSET:  amp_expect = AMP_EXP_OFFSET;
         DTC_AMP_GAIN_LO: amp_expect = AMP_EXP_GAIN_LO;
         DTC_AMP_GAIN_HI: amp_expect = AMP_EXP_GAIN_HI;
         default:         amp_expect = AMP_EXP_NONE;
      endcase
      amp_exclude = (amp_mode != DTC_AMP_NORMAL);                        // [R14]
   end
endmodule : dtc_decode

// ### design/dtc_pkg.sv
// package for the diagnostic test configuration register bank
package dtc_pkg;
   // ------------------------------------------------------------
   // register bus and offsets
   // ------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 16;
   localparam logic [7:0]  OFF_CELL_TST    = 8'h6c;   // cell_test_source_cfg
   localparam logic [7:0]  OFF_AUX_TST     = 8'h6d;   // aux_test_source_cfg
   localparam logic [7:0]  OFF_GEN_DIAG    = 8'h6e;   // general_diag_cfg
   localparam logic [15:0] RST_CELL_TST    = 16'h0000;
   localparam logic [15:0] RST_AUX_TST     = 16'h0000;
   localparam logic [15:0] RST_GEN_DIAG    = 16'h0000;
   localparam logic [15:0] MASK_CELL_TST   = 16'hffff;
   localparam logic [15:0] MASK_AUX_TST    = 16'h003f;
   localparam logic [15:0] MASK_GEN_DIAG   = 16'hf800;
   localparam logic [15:0] UNMAPPED_READ   = 16'h0000;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int          CELL_N          = 15;
   localparam int          OPEN_SEL_BIT    = 15;
   localparam int          AUX_N           = 4;
   localparam int          AMP_P_BIT       = 5;
   localparam int          AMP_N_BIT       = 4;
   localparam int          AUX_MODE_LSB    = 13;
   localparam int          AMP_MODE_LSB    = 11;
   // ------------------------------------------------------------
   // expected amplifier diagnostic results
   // ------------------------------------------------------------
   localparam logic [15:0] AMP_EXP_NONE    = 16'h0000;
   localparam logic [15:0] AMP_EXP_OFFSET  = 16'h2000;
   localparam logic [15:0] AMP_EXP_GAIN_LO = 16'h3800;
   localparam logic [15:0] AMP_EXP_GAIN_HI = 16'h3ffc;
   localparam logic [2:0]  SCAN_CMP_ONLY   = 3'b010;  // advised scan_configuration
   localparam logic        DIR_PULL_UP     = 1'b1;

   typedef enum logic [2:0] {
      DTC_AUX_NORMAL0   = 3'b000,
      DTC_AUX_NORMAL1   = 3'b001,
      DTC_AUX_DISCHARGE = 3'b010,
      DTC_AUX_THERMISTOR_BIAS_OUTPUT_GND  = 3'b011
   } dtc_aux_mode_t;

   typedef enum logic [1:0] {
      DTC_AMP_NORMAL  = 2'b00,
      DTC_AMP_OFFSET  = 2'b01,
      DTC_AMP_GAIN_LO = 2'b10,
      DTC_AMP_GAIN_HI = 2'b11
   } dtc_amp_mode_t;

   // scan phase, gray coded along idle -> scanning
   typedef enum logic [0:0] {
      DTC_SCAN_IDLE = 1'b0,
      DTC_SCAN_RUN  = 1'b1
   } dtc_scan_t;
endpackage : dtc_pkg

// ### design/dtc_regs.sv
// diagnostic test configuration register bank with scan-start snapshot
//
// What this block does
// R1 - normal mode measures enabled cells, standard thresholds
// R2 - open mode measures enabled, non-polarity cells only
// R3 - open mode: low-side comparator, open-wire threshold
// R4 - software enables pulldowns, comparator-only scan
// R5 - each cell enable bit drives its source
// R6 - aux bits 5,4 drive amplifier p,n sources
// R7 - amplifier sources are pull-up only
// R8 - gpio pins ignore aux enable, readback kept
// R9 - aux bits 3..0 drive aux input sources
// R10 - serial master ignores aux bits 1,0
// R11 - aux diag mode decode, upper codes reserved
// R12 - aux diag only on aux analog pins
// R13 - amplifier diag mode decode with expected values
// R14 - amp diag results skip filter and limits
// R15 - fields sampled at each scan start
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module dtc_regs
   import dtc_pkg::*;
(
   input  wire logic                clk_in,           // 40 MHz clock
   input  wire logic                rst_b_in,         // sync reset, active low
   input  wire logic [ADDR_W-1:0]   addr_in,          // register address
   input  wire logic [DATA_W-1:0]   wdata_in,         // write data
   input  wire logic                wr_in,            // write strobe
   input  wire logic                rd_in,            // read strobe
   output logic      [DATA_W-1:0]   rdata_out,        // read data, cycle after rd
   input  wire logic                scan_start_in,    // pulse: a scan begins
   input  wire logic                scan_done_in,     // pulse: the scan ends
   input  wire logic [14:0]         chan_en_in,       // cell_channel_enable
   input  wire logic [14:0]         polarity_in,      // per-channel polarity
   input  wire logic [3:0]          gpio_en_in,       // general_io_pin_enable
   input  wire logic                ser_en_in,        // serial_master_enable
   input  wire logic [3:0]          aux_analog_in,    // pin configured as aux input
   input  wire logic [2:0]          scan_cfg_in,      // scan_configuration in use
   output logic                     scanning_out,     // a scan is running
   output logic [14:0]              meas_sel_out,     // cells measured
   output logic                     open_mode_out,    // open-wire diag active
   output logic                     cmp_low_only_out, // only low-side comparator
   output logic                     open_thr_out,     // use open_wire_threshold
   output logic                     adc_cells_out,    // adc cell sequence allowed
   output logic [14:0]              cell_src_out,     // cell current sources
   output logic [3:0]               aux_src_out,      // aux current sources
   output logic [1:0]               amp_src_out,      // amplifier p,n sources
   output logic                     amp_pullup_out,   // force pull-up on amp sources
   output logic [3:0]               aux_dis_out,      // accelerated discharge pins
   output logic                     thermistor_bias_output_gnd_out,     // thermistor bias to ground
   output logic [1:0]               amp_mode_out,     // amplifier diag mode
   output logic                     amp_exclude_out,  // skip amp filter and limits
   output logic [15:0]              amp_expect_out,   // expected amp result
   output logic                     open_advice_out   // open mode without advised setup
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] cell_cfg;
      logic [15:0] aux_cfg;
      logic [15:0] gen_cfg;
      logic [15:0] s_cell;
      logic [15:0] s_aux;
      logic [15:0] s_gen;
      logic [14:0] s_chan;
      logic [14:0] s_pol;
      logic [3:0]  s_gpio;
      logic        s_ser;
      logic [3:0]  s_ana;
      dtc_scan_t   phase;
      logic [15:0] rdata;
      logic [14:0] meas_sel;
      logic        open_mode;
      logic [14:0] cell_src;
      logic [3:0]  aux_src;
      logic [1:0]  amp_src;
      logic [3:0]  aux_dis;
      logic        thermistor_bias_output_gnd;
      logic [1:0]  amp_mode;
      logic        amp_exclude;
      logic [15:0] amp_expect;
      logic        advice;
   } dtc_state_t;

   dtc_state_t  st;
   dtc_state_t  next_st;

   dtc_snap_if  snap ();

   logic [14:0] d_meas;
   logic        d_open;
   logic [14:0] d_cell;
   logic [3:0]  d_aux;
   logic [1:0]  d_amp;
   logic [3:0]  d_dis;
   logic        d_thermistor_bias_output;
   logic [1:0]  d_mode;
   logic        d_excl;
   logic [15:0] d_exp;

   // ------------------------------------------------------------
   // snapshot feeds the decoder; settings change only between scans
   // ------------------------------------------------------------
   assign snap.cell_cfg   = st.s_cell;
   assign snap.aux_cfg    = st.s_aux;
   assign snap.gen_cfg    = st.s_gen;
   assign snap.chan_en    = st.s_chan;
   assign snap.polarity   = st.s_pol;
   assign snap.gpio_en    = st.s_gpio;
   assign snap.ser_en     = st.s_ser;
   assign snap.aux_analog = st.s_ana;

   dtc_decode u_decode (
      .snap          (snap),
      .meas_sel      (d_meas),
      .open_mode     (d_open),
      .cell_src_on   (d_cell),
      .aux_src_on    (d_aux),
      .amp_src_on    (d_amp),
      .aux_discharge (d_dis),
      .thermistor_bias_output_gnd      (d_thermistor_bias_output),
      .amp_mode      (d_mode),
      .amp_exclude   (d_excl),
      .amp_expect    (d_exp)
   );

   // readback of one register, reserved bits read zero
   function automatic logic [15:0] read_reg(input logic [7:0] a, input dtc_state_t s);
      case (a)
         OFF_CELL_TST: read_reg = s.cell_cfg & MASK_CELL_TST;
         OFF_AUX_TST:  read_reg = s.aux_cfg & MASK_AUX_TST;
         OFF_GEN_DIAG: read_reg = s.gen_cfg & MASK_GEN_DIAG;
         default:      read_reg = UNMAPPED_READ;
      endcase
   endfunction : read_reg

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      // bus writes; ignored enable bits still store so readback matches [R8] [R10]
      if (wr_in) begin
         case (addr_in)
            OFF_CELL_TST: next_st.cell_cfg = wdata_in & MASK_CELL_TST;
            OFF_AUX_TST:  next_st.aux_cfg  = wdata_in & MASK_AUX_TST;
            OFF_GEN_DIAG: next_st.gen_cfg  = wdata_in & MASK_GEN_DIAG;
            default:      next_st.rdata    = st.rdata;  // unmapped write dropped
         endcase
      end
      next_st.rdata = rd_in ? read_reg(addr_in, st) : UNMAPPED_READ;
      // snapshot taken on scan start, held through the scan [R15]
      case (st.phase)
         DTC_SCAN_IDLE: begin
            if (scan_start_in) begin
               next_st.phase  = DTC_SCAN_RUN;
               next_st.s_cell = st.cell_cfg;
               next_st.s_aux  = st.aux_cfg;
               next_st.s_gen  = st.gen_cfg;
               next_st.s_chan = chan_en_in;
               next_st.s_pol  = polarity_in;
               next_st.s_gpio = gpio_en_in;
               next_st.s_ser  = ser_en_in;
               next_st.s_ana  = aux_analog_in;
            end
         end
         DTC_SCAN_RUN: begin
            if (scan_done_in) begin
               next_st.phase = DTC_SCAN_IDLE;
            end
         end
         default: next_st.phase = DTC_SCAN_IDLE;
      endcase
      // registered copies of the decode so every decoded output is a flop
      next_st.meas_sel    = d_meas;                  // [R1] [R2]
      next_st.open_mode   = d_open;                  // [R3]
      next_st.cell_src    = d_cell;                  // [R5]
      next_st.aux_src     = d_aux;                   // [R9]
      next_st.amp_src     = d_amp;                   // [R6]
      next_st.aux_dis     = d_dis;                   // [R12]
      next_st.thermistor_bias_output_gnd    = d_thermistor_bias_output;                  // [R11]
      next_st.amp_mode    = d_mode;                  // [R13]
      next_st.amp_exclude = d_excl;                  // [R14]
      next_st.amp_expect  = d_exp;
      // flag open mode run without pulldowns or comparator-only scan
      next_st.advice = d_open && ((d_cell & d_meas) != d_meas || scan_cfg_in != SCAN_CMP_ONLY); // [R4]
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         next_st_reset();
      end else begin
         st <= next_st;
      end
   end

   // reset value of every field
   task automatic next_st_reset();
      st          <= '0;
      st.cell_cfg <= RST_CELL_TST;
      st.aux_cfg  <= RST_AUX_TST;
      st.gen_cfg  <= RST_GEN_DIAG;
      st.phase    <= DTC_SCAN_IDLE;
   endtask : next_st_reset

   // ------------------------------------------------------------
   // outputs from flops, amp_pullup_out tied to DIR_PULL_UP
   // ------------------------------------------------------------
   assign rdata_out        = st.rdata;
   assign scanning_out     = (st.phase == DTC_SCAN_RUN);
   assign meas_sel_out     = st.meas_sel;
   assign open_mode_out    = st.open_mode;
   assign cmp_low_only_out = st.open_mode;            // [R3]
   assign open_thr_out     = st.open_mode;            // [R3]
   assign adc_cells_out    = ~st.open_mode;           // [R1]
   assign cell_src_out     = st.cell_src;
   assign aux_src_out      = st.aux_src;
   assign amp_src_out      = st.amp_src;
   assign amp_pullup_out   = DIR_PULL_UP;             // [R7]
   assign aux_dis_out      = st.aux_dis;
   assign thermistor_bias_output_gnd_out     = st.thermistor_bias_output_gnd;
   assign amp_mode_out     = st.amp_mode;
   assign amp_exclude_out  = st.amp_exclude;
   assign amp_expect_out   = st.amp_expect;
   assign open_advice_out  = st.advice;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_open_sel_mask: assert property (@(posedge clk_in) disable iff (!rst_b_in)  // [R2]
      st.s_cell[OPEN_SEL_BIT] |=> (meas_sel_out == ($past(st.s_chan) & ~$past(st.s_pol))))
      else $error("open mode selection wrong");
   a_normal_sel: assert property (@(posedge clk_in) disable iff (!rst_b_in)     // [R1]
      !st.s_cell[OPEN_SEL_BIT] |=> (meas_sel_out == $past(st.s_chan) && adc_cells_out))
      else $error("normal selection wrong");
   a_open_low_cmp: assert property (@(posedge clk_in) disable iff (!rst_b_in)   // [R3]
      open_mode_out |-> (cmp_low_only_out && open_thr_out && !adc_cells_out))
      else $error("open mode comparator setup wrong");
   a_cell_src_map: assert property (@(posedge clk_in) disable iff (!rst_b_in)   // [R5]
      1'b1 |=> (cell_src_out == $past(st.s_cell[14:0])))
      else $error("cell source mismatch");
   a_amp_src_map: assert property (@(posedge clk_in) disable iff (!rst_b_in)    // [R6]
      1'b1 |=> (amp_src_out == {$past(st.s_aux[5]), $past(st.s_aux[4])} && amp_pullup_out))
      else $error("amp source mismatch");
   a_gpio_ignore: assert property (@(posedge clk_in) disable iff (!rst_b_in)    // [R8]
      1'b1 |=> ((aux_src_out & $past(st.s_gpio)) == 4'h0))
      else $error("gpio pin source not ignored");
   a_ser_ignore: assert property (@(posedge clk_in) disable iff (!rst_b_in)     // [R10]
      st.s_ser |=> (aux_src_out[1:0] == 2'b00))
      else $error("serial master source not ignored");
   a_aux_src_map: assert property (@(posedge clk_in) disable iff (!rst_b_in)    // [R9]
      (!st.s_ser && st.s_gpio == 4'h0) |=> (aux_src_out == $past(st.s_aux[3:0])))
      else $error("aux source mismatch");
   a_aux_mode_dec: assert property (@(posedge clk_in) disable iff (!rst_b_in)   // [R11]
      (st.s_gen[15:14] != 2'b01) |=> (aux_dis_out == 4'h0 && !thermistor_bias_output_gnd_out))
      else $error("aux diag active in normal or reserved mode");
   a_aux_pins_only: assert property (@(posedge clk_in) disable iff (!rst_b_in)  // [R12]
      1'b1 |=> ((aux_dis_out & ~$past(st.s_ana)) == 4'h0))
      else $error("discharge on non aux pin");
   a_amp_expect: assert property (@(posedge clk_in) disable iff (!rst_b_in)     // [R13]
      (st.s_gen[12:11] == 2'b11) |=> (amp_expect_out == 16'h3ffc))
      else $error("gain high expectation wrong");
   a_amp_exclude: assert property (@(posedge clk_in) disable iff (!rst_b_in)    // [R14]
      1'b1 |=> (amp_exclude_out == ($past(st.s_gen[12:11]) != 2'b00)))
      else $error("amp exclusion wrong");
   a_scan_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)      // [R15]
      (scanning_out && !scan_done_in) |=> $stable(st.s_cell) && $stable(st.s_gen))
      else $error("snapshot changed mid scan");
   a_read_latency: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (rd_in && addr_in == OFF_AUX_TST && !wr_in) |=> (rdata_out == $past(st.aux_cfg)))
      else $error("aux readback wrong");
endmodule : dtc_regs

// ### design/dtc_snap_if.sv
// interface carrying the scan snapshot from the register bank to the decoder
`timescale 1ns/1ps
interface dtc_snap_if;
   logic [15:0] cell_cfg;   // snapshot of cell_test_source_cfg
   logic [15:0] aux_cfg;    // snapshot of aux_test_source_cfg
   logic [15:0] gen_cfg;    // snapshot of general_diag_cfg
   logic [14:0] chan_en;    // cell_channel_enable
   logic [14:0] polarity;   // per-channel polarity
   logic [3:0]  gpio_en;    // general_io_pin_enable
   logic        ser_en;     // serial_master_enable
   logic [3:0]  aux_analog; // pin is an aux_analog_input
   modport src (output cell_cfg, aux_cfg, gen_cfg, chan_en, polarity, gpio_en, ser_en,
                aux_analog);
   modport dst (input cell_cfg, aux_cfg, gen_cfg, chan_en, polarity, gpio_en, ser_en,
                aux_analog);
endinterface : dtc_snap_if
